// ### vtadc_map.svh
// register offsets, field positions, reset values and timing counts
// assumes the register port carries the 8-bit register pointer
// Summary of operation
// RULE_01: chipset supply above high or below low limit sets its status bit.
// RULE_02: a chipset supply limit event can pull the alert output low.
// RULE_03: low limit resets to 0x00, high limit to 0xff, so no event.
// RULE_04: one conversion lasts 711 us; sixteen make one averaged measurement.
// RULE_05: a value register loads only after sixteen averaged readings.
// RULE_06: config 2 bit 4 turns averaging off; one conversion per result.
// RULE_07: config 2 bit 5 bypasses the chipset supply input attenuator.
// RULE_08: config 2 bit 6 repeats one selected channel every 711 us.
// RULE_09: first tach min high byte bits 7:5 pick the single channel.
// RULE_10: converter codes are unsigned 10-bit, 0 to 1023, saturating; temperature channel codes are sign-extended here.
// RULE_11: local sensor result's eight high bits go to local temperature.
// RULE_12: temperatures stored twos complement or offset-64 extended, quarter degree.
// RULE_13: two low bits of each temperature go to extended resolution 2.
// RULE_14: diode fault in twos complement reports 1000 0000 00.
// RULE_15: diode fault in extended format reports 0000 0000 00.
// RULE_16: alert is released only after the limit condition has gone; here setting config 2 bit 1 also releases it while the condition remains.
// RULE_17: compare eight high result bits against limits at each value update.
// RULE_18: without single mode, channels are converted round robin in turn.
`ifndef VTADC_MAP_SVH
`define VTADC_MAP_SVH

`define VTADC_OFS_STATUS      8'h41
`define VTADC_OFS_CHIP_RD     8'h21
`define VTADC_OFS_DEV_RD      8'h22
`define VTADC_OFS_LOCAL_T     8'h26
`define VTADC_OFS_CHIP_LO     8'h46
`define VTADC_OFS_CHIP_HI     8'h47
`define VTADC_OFS_CHAN_SEL    8'h55
`define VTADC_OFS_CONFIG2     8'h73
`define VTADC_OFS_EXT_RES2    8'h77

`define VTADC_RST_CHIP_LO     8'h00
`define VTADC_RST_CHIP_HI     8'hff
`define VTADC_RST_ZERO        8'h00

`define VTADC_BIT_EXT_FMT     0
`define VTADC_BIT_ALERT_MASK  1
`define VTADC_BIT_AVG_OFF     4
`define VTADC_BIT_ATTEN_BYP   5
`define VTADC_BIT_SINGLE      6
`define VTADC_BIT_ST_LOW      0
`define VTADC_BIT_ST_HIGH     1

`define VTADC_EXT_LSB_REM1    2
`define VTADC_EXT_LSB_LOCAL   4
`define VTADC_EXT_LSB_REM2    6

`define VTADC_CLK_PERIOD_NS   10
`define VTADC_CONV_TIME_NS    711000
`define VTADC_CONV_CYCLES     (`VTADC_CONV_TIME_NS / `VTADC_CLK_PERIOD_NS)
`define VTADC_AVG_COUNT       16
`define VTADC_TC_FAULT        10'h200
`define VTADC_EXT_FAULT       10'h000
`define VTADC_EXT_OFFSET      10'h100

`endif

// ### vtadc_pkg.sv
// types shared by the measurement sequencer
// assumes nothing beyond the map header
package vtadc_pkg;
    typedef enum logic [2:0] {
        VTADC_CH_CHIP  = 3'h1,
        VTADC_CH_DEV   = 3'h2,
        VTADC_CH_REM1  = 3'h5,
        VTADC_CH_LOCAL = 3'h6,
        VTADC_CH_REM2  = 3'h7
    } vtadc_chan_t;

    typedef enum logic [1:0] {
        VTADC_ST_CONV  = 2'h0,
        VTADC_ST_ACCUM = 2'h1,
        VTADC_ST_STORE = 2'h3
    } vtadc_state_t;
endpackage

// ### vtadc_seq.sv
// measurement sequencer with register file for a multiplexed 10-bit converter
// assumes the analog front end returns a settled code at the end of each slot
`timescale 1ns/1ps
`include "vtadc_map.svh"

module vtadc_seq #(
    parameter int CONV_CYCLES = `VTADC_CONV_CYCLES,
    parameter int AVG_COUNT   = `VTADC_AVG_COUNT
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic [9:0] adc_code,
    input  wire logic       diode_fault,
    output logic      [2:0] adc_chan,
    output logic            adc_start,
    output logic            atten_bypass,
    output logic            smbalert_n
);
    localparam int CW = $clog2(CONV_CYCLES + 1);
    localparam int AW = $clog2(AVG_COUNT);

    vtadc_pkg::vtadc_state_t state_reg;
    vtadc_pkg::vtadc_state_t state_next;
    vtadc_pkg::vtadc_chan_t  chan_reg;
    vtadc_pkg::vtadc_chan_t  chan_next;
    logic [CW-1:0] conv_cnt_reg;
    logic [AW-1:0] samp_cnt_reg;
    logic [13:0]   accum_reg;
    logic          fault_reg;
    logic [7:0]    chip_rd_reg;
    logic [7:0]    dev_rd_reg;
    logic [7:0]    local_t_reg;
    logic [7:0]    chip_lo_reg;
    logic [7:0]    chip_hi_reg;
    logic [7:0]    chan_sel_reg;
    logic [7:0]    config2_reg;
    logic [7:0]    ext_res2_reg;
    logic [1:0]    cond_reg;
    logic [1:0]    status_reg;
    logic [1:0]    status_next;
    logic [7:0]    reg_rdata_reg;
    logic [2:0]    adc_chan_reg;
    logic          adc_start_reg;
    logic          atten_reg;
    logic          alert_n_reg;

    // decoding used by several places
    function automatic logic is_temp(input vtadc_pkg::vtadc_chan_t c);
        return c == vtadc_pkg::VTADC_CH_REM1 || c == vtadc_pkg::VTADC_CH_LOCAL || c == vtadc_pkg::VTADC_CH_REM2;
    endfunction

    function automatic vtadc_pkg::vtadc_chan_t rr_next(input vtadc_pkg::vtadc_chan_t c);
        case (c)
            vtadc_pkg::VTADC_CH_CHIP:  return vtadc_pkg::VTADC_CH_DEV;
            vtadc_pkg::VTADC_CH_DEV:   return vtadc_pkg::VTADC_CH_REM1;
            vtadc_pkg::VTADC_CH_REM1:  return vtadc_pkg::VTADC_CH_LOCAL;
            vtadc_pkg::VTADC_CH_LOCAL: return vtadc_pkg::VTADC_CH_REM2;
            default:                   return vtadc_pkg::VTADC_CH_CHIP;
        endcase
    endfunction

    function automatic vtadc_pkg::vtadc_chan_t sel_chan(input logic [2:0] code);
        case (code)
            3'h1, 3'h2, 3'h5, 3'h6, 3'h7: return vtadc_pkg::vtadc_chan_t'(code);
            default:                      return vtadc_pkg::VTADC_CH_CHIP;
        endcase
    endfunction

    // configuration fields
    wire        avg_off    = config2_reg[`VTADC_BIT_AVG_OFF];      // RULE_06
    wire        single     = config2_reg[`VTADC_BIT_SINGLE];
    wire        ext_fmt    = config2_reg[`VTADC_BIT_EXT_FMT];
    wire        alert_mask = config2_reg[`VTADC_BIT_ALERT_MASK];
    wire [AW-1:0] samp_last = avg_off ? '0 : AW'(AVG_COUNT - 1);

    // register port decode
    wire wr_lo   = reg_wr && reg_addr == `VTADC_OFS_CHIP_LO;
    wire wr_hi   = reg_wr && reg_addr == `VTADC_OFS_CHIP_HI;
    wire wr_sel  = reg_wr && reg_addr == `VTADC_OFS_CHAN_SEL;
    wire wr_cfg2 = reg_wr && reg_addr == `VTADC_OFS_CONFIG2;
    wire rd_stat = reg_rd && reg_addr == `VTADC_OFS_STATUS;

    // sequencing
    wire conv_end   = conv_cnt_reg == CW'(CONV_CYCLES - 1);
    wire store      = state_reg == vtadc_pkg::VTADC_ST_STORE;
    wire temp_ch    = is_temp(chan_reg);
    wire [13:0] samp_ext = temp_ch ? {{4{adc_code[9]}}, adc_code} : {4'h0, adc_code};   // RULE_10
    wire [13:0] accum_sum = accum_reg + samp_ext;
    wire [9:0]  result    = avg_off ? accum_reg[9:0] : accum_reg[13:4];                // RULE_05
    wire [9:0]  temp_code = fault_reg ? (ext_fmt ? `VTADC_EXT_FAULT : `VTADC_TC_FAULT) // RULE_14 RULE_15
                          : (ext_fmt ? result + `VTADC_EXT_OFFSET : result);            // RULE_12
    wire        chip_store = store && chan_reg == vtadc_pkg::VTADC_CH_CHIP;
    wire [1:0]  cond_now   = {result[9:2] > chip_hi_reg, result[9:2] < chip_lo_reg};   // RULE_17
    wire [1:0]  cond_use   = chip_store ? cond_now : cond_reg;

    always_comb begin
        state_next = state_reg;
        chan_next  = chan_reg;
        case (state_reg)
            vtadc_pkg::VTADC_ST_CONV: begin
                if (conv_end) begin
                    state_next = vtadc_pkg::VTADC_ST_ACCUM;
                end
            end
            vtadc_pkg::VTADC_ST_ACCUM: begin
                state_next = samp_cnt_reg == samp_last ? vtadc_pkg::VTADC_ST_STORE : vtadc_pkg::VTADC_ST_CONV;
            end
            vtadc_pkg::VTADC_ST_STORE: begin
                state_next = vtadc_pkg::VTADC_ST_CONV;
                chan_next  = single ? sel_chan(chan_sel_reg[7:5]) : rr_next(chan_reg);   // RULE_08 RULE_09 RULE_18
            end
            default: begin
                state_next = vtadc_pkg::VTADC_ST_CONV;
            end
        endcase
    end

    // set wins over clear-on-read while the condition stays
    assign status_next = (rd_stat ? 2'h0 : status_reg) | cond_use;   // RULE_01 RULE_16

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg     <= vtadc_pkg::VTADC_ST_CONV;
            chan_reg      <= vtadc_pkg::VTADC_CH_CHIP;
            conv_cnt_reg  <= '0;
            adc_start_reg <= 1'b0;
        end else begin
            state_reg     <= state_next;
            chan_reg      <= chan_next;
            conv_cnt_reg  <= state_reg == vtadc_pkg::VTADC_ST_CONV && !conv_end ? conv_cnt_reg + CW'(1) : '0;   // RULE_04
            adc_start_reg <= state_reg != vtadc_pkg::VTADC_ST_CONV && state_next == vtadc_pkg::VTADC_ST_CONV;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            samp_cnt_reg <= '0;
            accum_reg    <= '0;
            fault_reg    <= 1'b0;
        end else if (state_reg == vtadc_pkg::VTADC_ST_ACCUM) begin
            samp_cnt_reg <= samp_cnt_reg + AW'(1);
            accum_reg    <= accum_sum;
            fault_reg    <= fault_reg | diode_fault;
        end else if (store) begin
            samp_cnt_reg <= '0;
            accum_reg    <= '0;
            fault_reg    <= 1'b0;
        end
    end

    // measurement results
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            chip_rd_reg  <= `VTADC_RST_ZERO;
            dev_rd_reg   <= `VTADC_RST_ZERO;
            local_t_reg  <= `VTADC_RST_ZERO;
            ext_res2_reg <= `VTADC_RST_ZERO;
        end else if (store) begin
            case (chan_reg)
                vtadc_pkg::VTADC_CH_CHIP: chip_rd_reg <= result[9:2];
                vtadc_pkg::VTADC_CH_DEV:  dev_rd_reg  <= result[9:2];
                vtadc_pkg::VTADC_CH_REM1: begin
                    ext_res2_reg[`VTADC_EXT_LSB_REM1 +: 2] <= temp_code[1:0];    // RULE_13
                end
                vtadc_pkg::VTADC_CH_LOCAL: begin
                    local_t_reg <= temp_code[9:2];                                // RULE_11
                    ext_res2_reg[`VTADC_EXT_LSB_LOCAL +: 2] <= temp_code[1:0];   // RULE_13
                end
                vtadc_pkg::VTADC_CH_REM2: begin
                    ext_res2_reg[`VTADC_EXT_LSB_REM2 +: 2] <= temp_code[1:0];    // RULE_13
                end
                default: begin
                    ext_res2_reg <= ext_res2_reg;
                end
            endcase
        end
    end

    // software registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            chip_lo_reg  <= `VTADC_RST_CHIP_LO;   // RULE_03
            chip_hi_reg  <= `VTADC_RST_CHIP_HI;   // RULE_03
            chan_sel_reg <= `VTADC_RST_ZERO;
            config2_reg  <= `VTADC_RST_ZERO;
        end else begin
            chip_lo_reg  <= wr_lo ? reg_wdata : chip_lo_reg;
            chip_hi_reg  <= wr_hi ? reg_wdata : chip_hi_reg;
            chan_sel_reg <= wr_sel ? reg_wdata : chan_sel_reg;
            config2_reg  <= wr_cfg2 ? reg_wdata : config2_reg;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cond_reg     <= 2'h0;
            status_reg   <= 2'h0;
            alert_n_reg  <= 1'b1;
            atten_reg    <= 1'b0;
            adc_chan_reg <= 3'h1;
        end else begin
            cond_reg     <= cond_use;
            status_reg   <= status_next;
            alert_n_reg  <= !(|status_next && !alert_mask);          // RULE_02 RULE_16
            atten_reg    <= config2_reg[`VTADC_BIT_ATTEN_BYP];        // RULE_07
            adc_chan_reg <= chan_next;
        end
    end

    // read data
    wire [7:0] rd_mux = reg_addr == `VTADC_OFS_CHIP_RD  ? chip_rd_reg :
                        reg_addr == `VTADC_OFS_DEV_RD   ? dev_rd_reg :
                        reg_addr == `VTADC_OFS_LOCAL_T  ? local_t_reg :
                        reg_addr == `VTADC_OFS_CHIP_LO  ? chip_lo_reg :
                        reg_addr == `VTADC_OFS_CHIP_HI  ? chip_hi_reg :
                        reg_addr == `VTADC_OFS_CHAN_SEL ? chan_sel_reg :
                        reg_addr == `VTADC_OFS_CONFIG2  ? config2_reg :
                        reg_addr == `VTADC_OFS_EXT_RES2 ? ext_res2_reg :
                        reg_addr == `VTADC_OFS_STATUS   ? {6'h00, status_reg} : 8'h00;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_reg <= rd_mux;
        end
    end

    assign reg_rdata    = reg_rdata_reg;
    assign adc_chan     = adc_chan_reg;
    assign adc_start    = adc_start_reg;
    assign atten_bypass = atten_reg;
    assign smbalert_n   = alert_n_reg;

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    limit_hold_a: assert property (!wr_lo && !wr_hi |=> $stable(chip_lo_reg) && $stable(chip_hi_reg)) // RULE_03
        else $error("limit changed without a write");
    high_status_a: assert property (chip_store && result[9:2] > chip_hi_reg |=> status_reg[1]) // RULE_01
        else $error("high limit event not flagged");
    low_status_a: assert property (chip_store && result[9:2] < chip_lo_reg |=> status_reg[0]) // RULE_01
        else $error("low limit event not flagged");
    alert_drive_a: assert property (##1 smbalert_n == !(|status_reg && !$past(alert_mask))) // RULE_02
        else $error("alert line disagrees with status");
    alert_hold_a: assert property (|cond_reg && !alert_mask && !chip_store |=> !smbalert_n) // RULE_16
        else $error("alert released while condition remains");
    slot_gap_a: assert property (adc_start |=> !adc_start [*8]) // RULE_04
        else $error("conversion slot too short");
    avg_count_a: assert property (store && !$past(avg_off) |-> $past(samp_cnt_reg) == AW'(AVG_COUNT - 1)) // RULE_05
        else $error("stored before sixteen readings");
    single_chan_a: assert property (store && single && chan_sel_reg[7:5] == 3'h6 |=> adc_chan == 3'h6) // RULE_08
        else $error("single channel not selected");
    fault_code_a: assert property (store && chan_reg == vtadc_pkg::VTADC_CH_LOCAL && fault_reg && !ext_fmt
                                   |=> local_t_reg == 8'h80) // RULE_14
        else $error("diode fault code wrong");
    atten_follow_a: assert property (##1 atten_bypass == $past(config2_reg[`VTADC_BIT_ATTEN_BYP])) // RULE_07
        else $error("attenuator bypass not following config");

    round_robin_c: cover property (store && !single && chan_reg == vtadc_pkg::VTADC_CH_REM2);
    alert_low_c:   cover property ($fell(smbalert_n));
    alert_rel_c:   cover property ($rose(smbalert_n));
    avg_off_c:     cover property (store && avg_off);
endmodule

// ### vtadc_fe_model.sv
// analog front end model: a settled code and fault flag per channel
// assumes the bench fills code_tab and flt_tab by hierarchy
`timescale 1ns/1ps
module vtadc_fe_model (
    input  wire logic       clk_sys,
    input  wire logic [2:0] adc_chan,
    input  wire logic       adc_start,
    output logic      [9:0] adc_code,
    output logic            diode_fault
);
    logic [9:0] code_tab [8];
    logic       flt_tab  [8];
    logic [2:0] prev_chan;
    int         cnt = 0;
    int         run = 0;
    int         last_run = 0;
    int         slot_gap = 0;
    int         meas_gap = 0;
    bit         order_err = 0;

    // unsigned 10-bit codes per selected channel
    assign adc_code    = code_tab[adc_chan];
    assign diode_fault = flt_tab[adc_chan];

    function automatic logic [2:0] succ(input logic [2:0] c);
        case (c)
            3'h1: succ = 3'h2;
            3'h2: succ = 3'h5;
            3'h5: succ = 3'h6;
            3'h6: succ = 3'h7;
            default: succ = 3'h1;
        endcase
    endfunction

    // slot spacing, run length and channel order seen at the pins
    always @(posedge clk_sys) begin
        cnt <= cnt + 1;
        if (adc_start) begin
            cnt       <= 1;
            prev_chan <= adc_chan;
            if (adc_chan == prev_chan) begin
                run      <= run + 1;
                slot_gap <= cnt;
            end else begin
                last_run <= run;
                run      <= 1;
                meas_gap <= cnt;
                if (last_run != 0 && adc_chan != succ(prev_chan)) order_err <= 1;
            end
        end
    end
endmodule

// ### tb.sv
// self-checking bench for the measurement sequencer
// assumes the front end model above and the map header
`timescale 1ns/1ps
`include "vtadc_map.svh"
module tb;
    localparam int CONV = 10;
    logic       clk_sys;
    logic       rst;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic [9:0] adc_code;
    logic       diode_fault;
    logic [2:0] adc_chan;
    logic       adc_start;
    logic       atten_bypass;
    logic       smbalert_n;
    int         fail_count = 0;
    int         checks = 0;
    logic [7:0] rv;

`define VT_CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end

    vtadc_seq #(.CONV_CYCLES(CONV), .AVG_COUNT(16)) DUT (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_code(adc_code),
        .diode_fault(diode_fault), .adc_chan(adc_chan), .adc_start(adc_start),
        .atten_bypass(atten_bypass), .smbalert_n(smbalert_n));
    vtadc_fe_model fe (.clk_sys(clk_sys), .adc_chan(adc_chan), .adc_start(adc_start),
        .adc_code(adc_code), .diode_fault(diode_fault));

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        #1 rv = reg_rdata;
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        `VT_CHK(rv, e)
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic t_regs();
        chk_reg(`VTADC_OFS_CHIP_LO, 8'h00);
        chk_reg(`VTADC_OFS_CHIP_HI, 8'hff);
        chk_reg(`VTADC_OFS_CHIP_RD, 8'h00);
        chk_reg(`VTADC_OFS_DEV_RD, 8'h00);
        chk_reg(`VTADC_OFS_STATUS, 8'h00);
        wr(`VTADC_OFS_CHIP_RD, 8'h5a);
        wr(8'h30, 8'h5a);
        chk_reg(`VTADC_OFS_CHIP_RD, 8'h00);
        chk_reg(8'h30, 8'h00);
        `VT_CHK(smbalert_n, 1'b1)
    endtask

    task automatic t_round_robin();
        fe.code_tab[1] = 10'h3ff; fe.code_tab[2] = 10'h300; fe.code_tab[5] = 10'h029;
        fe.code_tab[6] = 10'h066; fe.code_tab[7] = 10'h0cb;
        wait_cyc(1800);
        chk_reg(`VTADC_OFS_CHIP_RD, 8'hff);
        chk_reg(`VTADC_OFS_DEV_RD, 8'hc0);
        chk_reg(`VTADC_OFS_LOCAL_T, 8'h19);
        chk_reg(`VTADC_OFS_EXT_RES2, 8'he4);
        `VT_CHK(fe.last_run, 16)
        `VT_CHK(fe.slot_gap, CONV + 1)
        `VT_CHK(fe.meas_gap, CONV + 2)
        `VT_CHK(fe.order_err, 1'b0)
        `VT_CHK(smbalert_n, 1'b1)
    endtask

    task automatic t_limits();
        fe.code_tab[1] = 10'h200;
        wr(`VTADC_OFS_CHIP_HI, 8'h7f);
        wait_cyc(900);
        `VT_CHK(smbalert_n, 1'b0)
        chk_reg(`VTADC_OFS_STATUS, 8'h02);
        wr(`VTADC_OFS_CHIP_HI, 8'h80);
        wait_cyc(900);
        rd(`VTADC_OFS_STATUS);
        wait_cyc(2);
        `VT_CHK(smbalert_n, 1'b1)
        wr(`VTADC_OFS_CHIP_LO, 8'h81);
        wait_cyc(900);
        chk_reg(`VTADC_OFS_STATUS, 8'h01);
        wr(`VTADC_OFS_CONFIG2, 8'h02);
        wait_cyc(2);
        `VT_CHK(smbalert_n, 1'b1)
        wr(`VTADC_OFS_CONFIG2, 8'h00);
        wait_cyc(2);
        `VT_CHK(smbalert_n, 1'b0)
        wr(`VTADC_OFS_CHIP_LO, 8'h00);
        wait_cyc(900);
        `VT_CHK(smbalert_n, 1'b0)
        rd(`VTADC_OFS_STATUS);
        wait_cyc(2);
        `VT_CHK(smbalert_n, 1'b1)
        chk_reg(`VTADC_OFS_STATUS, 8'h00);
    endtask

    task automatic t_single();
        logic [2:0] chs [5];
        chs = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
        wr(`VTADC_OFS_CHAN_SEL, 8'hc0);
        wr(`VTADC_OFS_CONFIG2, 8'h71);
        wait_cyc(400);
        `VT_CHK(adc_chan, 3'h6)
        `VT_CHK(atten_bypass, 1'b1)
        `VT_CHK(fe.slot_gap, CONV + 2)
        chk_reg(`VTADC_OFS_LOCAL_T, 8'h59);
        fe.code_tab[6] = 10'h12c;
        wait_cyc(30);
        chk_reg(`VTADC_OFS_LOCAL_T, 8'h8b);
        fe.flt_tab[6] = 1'b1;
        wait_cyc(30);
        chk_reg(`VTADC_OFS_LOCAL_T, 8'h00);
        chk_reg(`VTADC_OFS_EXT_RES2, 8'hc4);
        wr(`VTADC_OFS_CONFIG2, 8'h50);
        wait_cyc(30);
        chk_reg(`VTADC_OFS_LOCAL_T, 8'h80);
        `VT_CHK(atten_bypass, 1'b0)
        fe.flt_tab[6] = 1'b0;
        foreach (chs[i]) begin
            wr(`VTADC_OFS_CHAN_SEL, {chs[i], 5'h00});
            wait_cyc(40);
            `VT_CHK(adc_chan, chs[i])
        end
        wr(`VTADC_OFS_CHAN_SEL, 8'h60);
        wait_cyc(40);
        `VT_CHK(adc_chan, 3'h1)
    endtask

    task automatic report_and_stop();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        report_and_stop();
    end

    initial begin
        rst = 1'b1; reg_addr = 8'h00; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
        for (int i = 0; i < 8; i++) begin
            fe.code_tab[i] = 10'h000;
            fe.flt_tab[i]  = 1'b0;
        end
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_round_robin();
        t_limits();
        t_single();
        report_and_stop();
    end
endmodule
